// *** verilog/efr_regs.svh ***
// register offsets, field positions, reset values of the error flag block
//==============================================================================
// Behaviour
// - eight-bit read-only error register, index 06h, reset 00h
// - bit 7 set on host FIFO write during anticollision/authentication
// - bit 7 set on host FIFO write between last-tx and last-rx
// - overheat sets bit 6, antenna drivers switch off
// - bit 5 set when peer field arrives late
// - late field checked only with framing 01
// - bit 4 set on write into full FIFO
// - bit 3 collision, cleared at receiver start-up
// - at 212/424 kbit collision bit reads one
// - bit 2 set on enabled CRC failure, start-up clears
// - bit 1 parity failure, 106 kbit only, start-up clears
// - bit 0 set on bad start-of-frame at 106
// - bit 0 on byte-length violation with sync detect
// - bit 0 when anticollision runs with initiator set
// - bit 0 on wrong authentication byte count
// - bit 0 on two too-short Miller pulses
// - command start clears all but bit 6; host cannot set
// - error request high while any flag set
`ifndef EFR_REGS_SVH
`define EFR_REGS_SVH

//==============================================================================
// register indexes; byte address is four times the index
`define EFR_ERR_IDX    8'h06
`define EFR_CTRL_IDX   8'h10
`define EFR_ISTAT_IDX  8'h11
`define EFR_IEN_IDX    8'h12
`define EFR_ICLR_IDX   8'h13

//==============================================================================
// error flag bit positions
`define EFR_B_WRV      7
`define EFR_B_TEMP     6
`define EFR_B_RF       5
`define EFR_B_OVFL     4
`define EFR_B_COLL     3
`define EFR_B_CRC      2
`define EFR_B_PAR      1
`define EFR_B_PROT     0

//==============================================================================
// control register fields
`define EFR_C_RXFR_LO  0
`define EFR_C_TXFR_LO  2
`define EFR_C_RATE_LO  4
`define EFR_C_CRCON    6
`define EFR_C_SYNC     7
`define EFR_C_INIT     8
`define EFR_C_TCLR     9
`define EFR_CTRL_W     9

//==============================================================================
// reset values
`define EFR_ERR_RST    8'h00
`define EFR_CTRL_RST   9'h000
`define EFR_IEN_RST    8'h00

`endif

// *** verilog/efr_pkg.sv ***
// types shared by the error flag block
package efr_pkg;
  // framing selection, 01 is active communication
  typedef enum logic [1:0] {
    EFR_FR_PASSIVE,
    EFR_FR_ACTIVE,
    EFR_FR_ALT_CARD,
    EFR_FR_TYPE_B
  } efr_framing_t;

  // link bit rate selection
  typedef enum logic [1:0] {
    EFR_R106,
    EFR_R212,
    EFR_R424,
    EFR_R848
  } efr_rate_t;

  // tx-to-rx window of a transceive
  typedef enum logic {
    EFR_WIN_IDLE,
    EFR_WIN_OPEN
  } efr_win_t;
endpackage

// *** verilog/efr_sync.sv ***
// two-stage level synchroniser
`timescale 1ns/1ps
module efr_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk,   // system clock
  input  wire logic rst,   // async reset, high
  input  wire logic d,     // asynchronous level
  output logic      q      // synchronised level
);
  import efr_pkg::*;

  logic [STAGES-1:0] sh_r;

  // elaboration check
  initial begin
    if (STAGES < 2) $error("efr_sync needs two stages at least");
  end

  // shift chain, only the last stage is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[STAGES-2:0], d};
    end
  end

  assign q = sh_r[STAGES-1];
endmodule // efr_sync

// *** verilog/efr_irq.sv ***
// sticky interrupt status with enable and write-one clear
`timescale 1ns/1ps
module efr_irq #(
  parameter int W = 8
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst,      // async reset, high
  input  wire logic [W-1:0] evt,      // event pulses
  input  wire logic         en_wr,    // enable register write
  input  wire logic         clr_wr,   // clear register write
  input  wire logic [W-1:0] wdata,    // write data
  output logic      [W-1:0] status,   // sticky status
  output logic      [W-1:0] enable,   // enable mask
  output logic              irq       // level interrupt
);
  import efr_pkg::*;

  initial begin
    if (W < 1 || W > 32) $error("efr_irq width out of range");
  end

  // sticky bits, a new event wins over a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~(clr_wr ? wdata : '0)) | evt;
    end
  end

  // enable mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= '0;
    end else if (en_wr) begin
      enable <= wdata;
    end
  end

  // registered level request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~(clr_wr ? wdata : '0)) | evt) & (en_wr ? wdata : enable));
    end
  end
endmodule // efr_irq

// *** verilog/efr_top.sv ***
// error flag register of the contactless frontend, with APB access
`timescale 1ns/1ps
`include "efr_regs.svh"
module efr_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,            // system clock, 250 MHz
  input  wire logic              rst,            // async reset, high
  // apb slave
  input  wire logic              psel,           // slave select
  input  wire logic              penable,        // access phase
  input  wire logic              pwrite,         // write direction
  input  wire logic [ADDR_W-1:0] paddr,          // byte address
  input  wire logic [31:0]       pwdata,         // write data
  output logic      [31:0]       prdata,         // read data
  output logic                   pready,         // transfer done
  output logic                   pslverr,        // unmapped address
  // command engine
  input  wire logic              cmd_start,      // command starts, pulse
  input  wire logic              auto_anticollision_cmd, // command running
  input  wire logic              card_authentication_cmd, // command running
  input  wire logic              auth_count_bad, // wrong byte count, pulse
  // fifo
  input  wire logic              host_fifo_wr,   // host fifo write, pulse
  input  wire logic              int_fifo_wr,    // internal fifo write, pulse
  input  wire logic              fifo_full,      // fifo full level
  // transceiver
  input  wire logic              tx_last_bit,    // last bit sent, pulse
  input  wire logic              rx_last_bit,    // last bit received, pulse
  input  wire logic              rx_startup,     // receiver start-up, pulse
  input  wire logic              peer_field_timeout, // field late, pulse
  input  wire logic              collision_det,  // bit collision, pulse
  input  wire logic              crc_bad,        // crc check failed, pulse
  input  wire logic              parity_bad,     // parity failed, pulse
  input  wire logic              sof_bad,        // bad start of frame, pulse
  input  wire logic              byte_len_bad,   // byte length violation, pulse
  input  wire logic              miller_short,   // two short pulses, pulse
  // temperature sensor
  input  wire logic              overheat_async, // sensor level, async
  // outputs
  output logic      [7:0]        error_flags,    // error register copy
  output logic                   error_irq_flag, // any error flag set
  output logic                   antenna_off,    // drivers disabled
  output logic                   irq             // enabled event request
);
  import efr_pkg::*;

  //==============================================================================
  // helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return (a[9:2] == idx) && (a[1:0] == 2'b00) && ((a >> 10) == '0);
  endfunction

  function automatic logic at106(input efr_rate_t r);
    return r == EFR_R106;
  endfunction

  initial begin
    if (ADDR_W < 10) $error("efr_top needs ADDR_W of 10 or more");
  end

  //==============================================================================
  // declarations
  logic [7:0]           err_r;
  logic [7:0]           err_nxt;
  logic [7:0]           set_v;
  logic [`EFR_CTRL_W-1:0] ctrl_r;
  logic                 temp_clr_r;
  efr_win_t             win_r;
  logic                 overheat;
  logic                 setup;
  logic                 acc;
  logic                 wr_acc;
  logic                 mapped;
  logic [7:0]           ist;
  logic [7:0]           ien;
  logic                 irq_int;
  efr_framing_t         rx_fr;
  efr_framing_t         tx_fr;
  efr_rate_t            rate;
  logic                 crc_on;
  logic                 sync_on;
  logic                 initiator;
  logic                 fast_coll;
  logic                 active_mode;

  //==============================================================================
  // control fields
  assign rx_fr     = efr_framing_t'(ctrl_r[`EFR_C_RXFR_LO +: 2]);
  assign tx_fr     = efr_framing_t'(ctrl_r[`EFR_C_TXFR_LO +: 2]);
  assign rate      = efr_rate_t'(ctrl_r[`EFR_C_RATE_LO +: 2]);
  assign crc_on    = ctrl_r[`EFR_C_CRCON];
  assign sync_on   = ctrl_r[`EFR_C_SYNC];
  assign initiator = ctrl_r[`EFR_C_INIT];
  assign active_mode = (rx_fr == EFR_FR_ACTIVE) || (tx_fr == EFR_FR_ACTIVE);
  assign fast_coll = (rate == EFR_R212) || (rate == EFR_R424);

  //==============================================================================
  // temperature sensor crossing
  efr_sync #(
    .STAGES (2)
  ) u_sync_temp (
    .clk (clk),
    .rst (rst),
    .d   (overheat_async),
    .q   (overheat)
  );

  //==============================================================================
  // apb phase decode
  assign setup  = psel && !penable;
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign mapped = hit(paddr, `EFR_ERR_IDX) || hit(paddr, `EFR_CTRL_IDX) ||
                  hit(paddr, `EFR_ISTAT_IDX) || hit(paddr, `EFR_IEN_IDX) ||
                  hit(paddr, `EFR_ICLR_IDX);

  // ready one cycle after setup, no wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= '0;
      if (!pwrite) begin
        if (hit(paddr, `EFR_ERR_IDX)) begin
          prdata <= {24'h000000, err_r};
        end else if (hit(paddr, `EFR_CTRL_IDX)) begin
          prdata <= {23'h000000, ctrl_r};
        end else if (hit(paddr, `EFR_ISTAT_IDX)) begin
          prdata <= {24'h000000, ist};
        end else if (hit(paddr, `EFR_IEN_IDX)) begin
          prdata <= {24'h000000, ien};
        end
      end
    end
  end

  // control register; the clear strobe bit reads back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= `EFR_CTRL_RST;
      temp_clr_r <= 1'b0;
    end else begin
      temp_clr_r <= 1'b0;
      if (wr_acc && hit(paddr, `EFR_CTRL_IDX)) begin
        ctrl_r     <= pwdata[`EFR_CTRL_W-1:0];
        temp_clr_r <= pwdata[`EFR_C_TCLR];
      end
    end
  end

  //==============================================================================
  // transceive window: from last bit sent to last bit received
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_r <= EFR_WIN_IDLE;
    end else begin
      unique case (win_r)
        EFR_WIN_IDLE: begin
          if (tx_last_bit) begin
            win_r <= EFR_WIN_OPEN;
          end
        end
        EFR_WIN_OPEN: begin
          if (rx_last_bit || cmd_start) begin
            win_r <= EFR_WIN_IDLE;
          end
        end
      endcase
    end
  end

  //==============================================================================
  // set conditions of each flag
  always_comb begin
    set_v = 8'h00;
    set_v[`EFR_B_WRV]  = host_fifo_wr &&
                         (auto_anticollision_cmd || card_authentication_cmd);
    set_v[`EFR_B_WRV]  = set_v[`EFR_B_WRV] ||
                         (host_fifo_wr && win_r == EFR_WIN_OPEN);
    set_v[`EFR_B_TEMP] = overheat;
    set_v[`EFR_B_RF]   = peer_field_timeout && active_mode;
    set_v[`EFR_B_OVFL] = (host_fifo_wr || int_fifo_wr) && fifo_full;
    set_v[`EFR_B_COLL] = collision_det;
    set_v[`EFR_B_CRC]  = crc_bad && crc_on;
    set_v[`EFR_B_PAR]  = parity_bad && at106(rate) &&
                         (rx_fr == EFR_FR_PASSIVE || rx_fr == EFR_FR_ACTIVE);
    set_v[`EFR_B_PROT] = (sof_bad && at106(rate)) ||
                         (byte_len_bad && sync_on &&
                          (rx_fr == EFR_FR_ALT_CARD ||
                           (rx_fr == EFR_FR_ACTIVE && !at106(rate)))) ||
                         (auto_anticollision_cmd && initiator) ||
                         (auth_count_bad && card_authentication_cmd) ||
                         miller_short;
  end

  //==============================================================================
  // next value: clear events first, then sets win
  always_comb begin
    err_nxt = err_r;
    if (cmd_start) begin
      err_nxt = err_nxt & (8'h01 << `EFR_B_TEMP);
    end
    if (rx_startup) begin
      err_nxt[`EFR_B_COLL] = 1'b0;
      err_nxt[`EFR_B_CRC]  = 1'b0;
      err_nxt[`EFR_B_PAR]  = 1'b0;
      err_nxt[`EFR_B_PROT] = 1'b0;
    end
    if (temp_clr_r && !overheat) begin
      err_nxt[`EFR_B_TEMP] = 1'b0;
    end
    err_nxt = err_nxt | set_v;
    if (fast_coll) begin
      err_nxt[`EFR_B_COLL] = 1'b1;
    end
  end

  // error register; host writes never reach it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_r <= `EFR_ERR_RST;
    end else begin
      err_r <= err_nxt;
    end
  end

  //==============================================================================
  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_flags    <= `EFR_ERR_RST;
      error_irq_flag <= 1'b0;
      antenna_off    <= 1'b0;
    end else begin
      error_flags    <= err_nxt;
      error_irq_flag <= |err_nxt;
      antenna_off    <= err_nxt[`EFR_B_TEMP];
    end
  end

  //==============================================================================
  // interrupt: one status bit per newly set flag
  efr_irq #(
    .W (8)
  ) u_irq (
    .clk    (clk),
    .rst    (rst),
    .evt    (err_nxt & ~err_r),
    .en_wr  (wr_acc && hit(paddr, `EFR_IEN_IDX)),
    .clr_wr (wr_acc && hit(paddr, `EFR_ICLR_IDX)),
    .wdata  (pwdata[7:0]),
    .status (ist),
    .enable (ien),
    .irq    (irq_int)
  );

  assign irq = irq_int;
endmodule // efr_top

// *** bench/efr_top_chk.sv ***
// port assertions of the error flag block
`timescale 1ns/1ps
module efr_top_chk (
  input wire logic       clk,                    // system clock
  input wire logic       rst,                    // async reset
  input wire logic       cmd_start,              // command start
  input wire logic       auto_anticollision_cmd, // command running
  input wire logic       host_fifo_wr,           // host fifo write
  input wire logic       fifo_full,              // fifo full
  input wire logic       tx_last_bit,            // last bit sent
  input wire logic       rx_last_bit,            // last bit received
  input wire logic       rx_startup,             // receiver start-up
  input wire logic       peer_field_timeout,     // field late
  input wire logic       crc_bad,                // crc failed
  input wire logic       overheat_async,         // sensor level
  input wire logic [7:0] error_flags,            // error register
  input wire logic       error_irq_flag,         // any flag set
  input wire logic       antenna_off             // drivers off
);
  //============================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // transceive window opens after the last sent bit
  sequence s_tx_done;
    tx_last_bit && !rx_last_bit && !cmd_start;
  endsequence
  sequence s_host_wr;
    host_fifo_wr && !rx_last_bit;
  endsequence
  // one idle cycle between the last sent bit and the host write, window stays open
  sequence s_win_gap;
    !rx_last_bit && !cmd_start;
  endsequence

  chk_irq_any: assert property (error_irq_flag == (error_flags != 8'h00))
    else $error("error request differs from flags");
  chk_antenna_temp: assert property (antenna_off == error_flags[6])
    else $error("antenna state differs from temperature flag");
  chk_temp_set: assert property (overheat_async [*4] |-> error_flags[6])
    else $error("temperature flag missing");
  chk_ovfl_set: assert property (host_fifo_wr && fifo_full |=> error_flags[4])
    else $error("overflow flag missing");
  chk_wr_busy: assert property (host_fifo_wr && auto_anticollision_cmd |=> error_flags[7])
    else $error("write violation missing in command");
  chk_wr_window: assert property (s_tx_done ##1 s_win_gap ##1 s_host_wr |=> error_flags[7])
    else $error("write violation missing in window");
  chk_cmd_clear: assert property (cmd_start && !host_fifo_wr && !fifo_full && !peer_field_timeout
                                  |=> (error_flags & 8'hB0) == 8'h00)
    else $error("command start left flags set");
  chk_crc_clear: assert property (rx_startup && !crc_bad |=> !error_flags[2])
    else $error("start-up left crc flag set");
  chk_wr_hold: assert property (error_flags[7] && !cmd_start |=> error_flags[7])
    else $error("write violation flag dropped");
endmodule // efr_top_chk

// *** bench/efr_host.sv ***
// host model: apb master with expected read queue
`timescale 1ns/1ps
module efr_host (
  input  wire logic        clk,     // system clock
  input  wire logic        pready,  // transfer done
  output logic             psel,    // slave select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic [11:0]      paddr,   // byte address
  output logic [31:0]      pwdata   // write data
);
  //============================================================
  // bus
  logic [32:0] q [$];  // expected {pslverr, prdata}

  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // setup, then access held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    xfer(1'b0, a, 32'h0);
  endtask
endmodule // efr_host

// *** bench/tb_efr_top.sv ***
// testbench of the error flag block
`timescale 1ns/1ps
`include "efr_regs.svh"
module tb_efr_top;
  //============================================================
  // signals
  localparam logic [11:0] A_ERR = {2'b00, `EFR_ERR_IDX, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, `EFR_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_IST = {2'b00, `EFR_ISTAT_IDX, 2'b00};
  localparam logic [11:0] A_IEN = {2'b00, `EFR_IEN_IDX, 2'b00};
  localparam logic [11:0] A_ICL = {2'b00, `EFR_ICLR_IDX, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] ev = 14'h0000; // event pulses
  logic [3:0]  lv = 4'h0;     // hot, full, auth, anticoll
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  error_flags;
  logic        error_irq_flag, antenna_off, irq;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  // {ctrl, levels, events, expected flags}
  logic [39:0] tbl [22] = '{40'h041_0_0080_20, 40'h004_0_0080_20, 40'h000_0_0080_00,
    40'h021_0_0000_08, 40'h041_0_0100_08, 40'h041_0_0200_04, 40'h091_0_1000_09,
    40'h001_0_0200_00, 40'h041_0_0400_02,
    40'h011_0_0400_08, 40'h041_0_0800_01, 40'h082_0_1000_01, 40'h002_0_1000_00,
    40'h041_0_2000_01, 40'h100_1_0000_01, 40'h000_1_0004_80, 40'h000_2_0004_80,
    40'h000_2_0002_01, 40'h000_0_0002_00, 40'h000_4_0004_10, 40'h000_4_0008_10,
    40'h000_0_0004_00};

  always #2 clk = ~clk;

  efr_host h (.clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  efr_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_start(ev[0]), .auto_anticollision_cmd(lv[0]), .card_authentication_cmd(lv[1]),
    .auth_count_bad(ev[1]), .host_fifo_wr(ev[2]), .int_fifo_wr(ev[3]), .fifo_full(lv[2]),
    .tx_last_bit(ev[4]), .rx_last_bit(ev[5]), .rx_startup(ev[6]), .peer_field_timeout(ev[7]),
    .collision_det(ev[8]), .crc_bad(ev[9]), .parity_bad(ev[10]), .sof_bad(ev[11]),
    .byte_len_bad(ev[12]), .miller_short(ev[13]), .overheat_async(lv[3]),
    .error_flags(error_flags), .error_irq_flag(error_irq_flag), .antenna_off(antenna_off), .irq(irq));

  //============================================================
  // checking
  task automatic cmp(input logic [32:0] g, input logic [32:0] x);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 14'h0000;
  endtask
  task results;
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // read results against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && h.q.size() > 0) cmp({pslverr, prdata}, h.q.pop_front());
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      results();
    end
  end

  //============================================================
  // stimulus
  initial begin
    void'($urandom(32'h83CDBA12));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    h.rd(A_ERR, 33'h0);
    h.rd(12'hFFC, 33'h1_0000_0000);
    h.wr(A_ERR, $urandom());
    h.rd(A_ERR, 33'h0);
    h.wr(A_IEN, 32'hFF);
    foreach (tbl[i]) begin
      h.wr(A_CTL, {20'h0, tbl[i][39:28]});
      pulse(14'h0001);
      lv[2:0] <= tbl[i][26:24];
      pulse(tbl[i][21:8]);
      h.rd(A_ERR, {25'h0, tbl[i][7:0]});
      h.rd(A_IST, {25'h0, tbl[i][7:0]});
      cmp({32'h0, irq}, {32'h0, tbl[i][7:0] != 8'h00});
      cmp({24'h0, error_irq_flag, error_flags}, {24'h0, tbl[i][7:0] != 8'h00, tbl[i][7:0]});
      lv[2:0] <= 3'h0;
      h.wr(A_ICL, 32'hFF);
    end
    // overheat survives a command start
    lv[3] <= 1'b1;
    repeat (6) @(posedge clk);
    h.rd(A_ERR, 33'h40);
    cmp({32'h0, antenna_off}, 33'h1);
    pulse(14'h0001);
    h.rd(A_ERR, 33'h40);
    lv[3] <= 1'b0;
    repeat (4) @(posedge clk);
    h.wr(A_CTL, 32'h200);
    h.rd(A_ERR, 33'h0);
    // host write inside and outside the transceive window
    pulse(14'h0010);
    pulse(14'h0004);
    h.rd(A_ERR, 33'h80);
    pulse(14'h0020);
    pulse(14'h0001);
    pulse(14'h0004);
    h.rd(A_ERR, 33'h0);
    // receiver start-up clears receive flags only
    h.wr(A_CTL, 32'h41);
    pulse(14'h0F80);
    h.rd(A_ERR, 33'h2F);
    pulse(14'h0040);
    h.rd(A_ERR, 33'h20);
    // masked event, then unmasked
    h.wr(A_ICL, 32'hFF);
    h.wr(A_IEN, 32'h00);
    pulse(14'h0200);
    h.rd(A_IST, 33'h04);
    cmp({32'h0, irq}, 33'h0);
    h.wr(A_IEN, 32'h04);
    repeat (2) @(posedge clk);
    cmp({32'h0, irq}, 33'h1);
    results();
  end
endmodule // tb_efr_top

bind efr_top efr_top_chk chk (.clk(clk), .rst(rst), .cmd_start(cmd_start),
  .auto_anticollision_cmd(auto_anticollision_cmd), .host_fifo_wr(host_fifo_wr), .fifo_full(fifo_full),
  .tx_last_bit(tx_last_bit), .rx_last_bit(rx_last_bit), .rx_startup(rx_startup),
  .peer_field_timeout(peer_field_timeout), .crc_bad(crc_bad), .overheat_async(overheat_async),
  .error_flags(error_flags), .error_irq_flag(error_irq_flag), .antenna_off(antenna_off));
